// ### design/pfe_pkg.sv
// Package: register map, field layouts and reset values of the flag bank
package pfe_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // Register offsets (word index on the register port)
  localparam logic [3:0] OFF_CAPCMP_FLAGS = 4'h0;
  localparam logic [3:0] OFF_TIMER_FLAGS  = 4'h1;
  localparam logic [3:0] OFF_SERIAL_FLAGS = 4'h2;
  localparam logic [3:0] OFF_ENABLE_ONE   = 4'h3;
  localparam logic [3:0] OFF_ENABLE_TWO   = 4'h4;
  localparam logic [3:0] OFF_ENABLE_THREE = 4'h5;
  localparam logic [3:0] OFF_CONTROL      = 4'h6;
  localparam logic [3:0] OFF_IRQ_STATUS   = 4'h7;
  localparam logic [3:0] OFF_IRQ_CLEAR    = 4'h8;
  localparam logic [3:0] OFF_IRQ_ENABLE   = 4'h9;

  // Implemented and software-writable bits per flag register
  localparam logic [7:0] CAPCMP_IMPL_MASK = 8'hFF;
  localparam logic [7:0] TIMER_IMPL_MASK  = 8'h77;
  localparam logic [7:0] SERIAL_IMPL_MASK = 8'hF7;
  localparam logic [7:0] SERIAL_SW_MASK   = 8'h07;

  // Bit positions, timer and tuning flags
  localparam int TMR4_MATCH_BIT  = 0;
  localparam int TMR5_OVF_BIT    = 1;
  localparam int TMR6_MATCH_BIT  = 2;
  localparam int TMR8_MATCH_BIT  = 4;
  localparam int TUNE_LOCK_BIT   = 5;
  localparam int TUNE_RANGE_BIT  = 6;

  // Bit positions, serial and comparator flags
  localparam int CMP1_BIT        = 0;
  localparam int SER3_TX_BIT     = 4;
  localparam int SER3_RX_BIT     = 5;
  localparam int SER4_TX_BIT     = 6;
  localparam int SER4_RX_BIT     = 7;

  // Control register fields
  localparam int GROUP_EN_BIT    = 0;
  localparam int PRIO_MODE_BIT   = 1;

  // Interrupt status fields
  localparam int ST_CAPCMP_BIT   = 0;
  localparam int ST_TIMER_BIT    = 1;
  localparam int ST_SERIAL_BIT   = 2;
  localparam int ST_REQUEST_BIT  = 3;
  localparam logic [3:0] ST_MASK = 4'hF;

  // Reset values
  localparam logic [7:0] FLAGS_RESET   = 8'h00;
  localparam logic [7:0] ENABLE_RESET  = 8'h00;
  localparam logic [1:0] CONTROL_RESET = 2'h0;
  localparam logic [3:0] STATUS_RESET  = 4'h0;

  // Channel mode encoding, two bits per channel
  localparam logic [1:0] MODE_OFF     = 2'h0;
  localparam logic [1:0] MODE_CAPTURE = 2'h1;
  localparam logic [1:0] MODE_COMPARE = 2'h2;
  localparam logic [1:0] MODE_PWM     = 2'h3;

endpackage

// ### design/pfe_bank.sv
// Peripheral interrupt flag and enable bank with register port
//
// Functional notes
// - flag bits 7..1 channels 10..4, bit0 enhanced 3
// - capture event sets channel flag until cleared
// - compare match sets channel flag until cleared
// - channels in PWM mode never set flags
// - tuning out-of-range sets timer register bit 6
// - tuning lock gained or lost sets bit 5
// - timers 8,6,4 period match set bits 4,2,0
// - timer five overflow sets bit 1
// - unimplemented bits ignore writes, read zero
// - receive full flags clear on buffer read
// - transmit empty flags clear on buffer write
// - comparators three..one set bits 2..0
// - without priority mode, group enable gates requests
// - enable two: osc fail down to timer3 gate
// - enable three: timer5 gate down to calendar
// - all flags and enables reset to zero
// - flags set regardless of their enables
//
// The strobed register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ps

module pfe_bank #(
  parameter int NUM_CH = 8
) (
  // Clock and reset
  input  wire logic                CLK,
  input  wire logic                RST_N,
  // Register port
  input  wire logic [3:0]          ADDR,
  input  wire logic [7:0]          WDATA,
  input  wire logic                WR,
  input  wire logic                RD,
  output logic      [7:0]          RDATA,
  // Capture/compare channels, bit i = flag bit i
  input  wire logic [2*NUM_CH-1:0] CC_MODE,
  input  wire logic [NUM_CH-1:0]   CC_CAPTURE,
  input  wire logic [NUM_CH-1:0]   CC_COMPARE,
  // Clock tuning
  input  wire logic                TUNE_RANGE_ERR,
  input  wire logic                TUNE_LOCKED,
  // Timers
  input  wire logic                TMR8_MATCH,
  input  wire logic                TMR6_MATCH,
  input  wire logic                TMR5_OVF,
  input  wire logic                TMR4_MATCH,
  // Serial ports three and four
  input  wire logic                SER4_RX_FULL,
  input  wire logic                SER4_TX_EMPTY,
  input  wire logic                SER3_RX_FULL,
  input  wire logic                SER3_TX_EMPTY,
  input  wire logic                SER4_RX_BUF_READ,
  input  wire logic                SER4_TX_BUF_WRITE,
  input  wire logic                SER3_RX_BUF_READ,
  input  wire logic                SER3_TX_BUF_WRITE,
  // Comparators three..one
  input  wire logic [2:0]          CMP_EVENT,
  // Flags kept elsewhere, gated by the three enable registers
  input  wire logic [7:0]          GRP1_FLAGS,
  input  wire logic [7:0]          GRP2_FLAGS,
  input  wire logic [7:0]          GRP3_FLAGS,
  // Enables kept elsewhere for the three local flag registers
  input  wire logic [7:0]          CAPCMP_EN,
  input  wire logic [7:0]          TIMER_EN,
  input  wire logic [7:0]          SERIAL_EN,
  // Requests
  output logic                     PERIPH_IRQ,
  output logic                     IRQ
);

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Channel event qualified by its mode; PWM and off produce nothing
  function automatic logic ch_event(input logic [1:0] mode,
                                    input logic       cap,
                                    input logic       cmp);
    logic hit;
    hit = 1'b0;
    case (mode)
      pfe_pkg::MODE_CAPTURE: hit = cap;
      pfe_pkg::MODE_COMPARE: hit = cmp;
      pfe_pkg::MODE_PWM:     hit = 1'b0;
      default:               hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Register port write hitting one offset
  function automatic logic wr_hit(input logic       wr,
                                  input logic [3:0] addr,
                                  input logic [3:0] off);
    return wr && (addr == off);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [7:0] capcmp_channel_event_flags;
  logic [7:0] timer_and_tuning_event_flags;
  logic [7:0] serial_and_comparator_event_flags;
  logic [7:0] peripheral_enable_group_one;
  logic [7:0] peripheral_enable_group_two;
  logic [7:0] peripheral_enable_group_three;
  logic       peripheral_group_enable;
  logic       priority_mode_enable;
  logic [3:0] irq_status;
  logic [3:0] irq_enable;

  logic [7:0] capcmp_set;
  logic [7:0] timer_set;
  logic [7:0] serial_set;
  logic [7:0] serial_auto_clr;
  logic       lock_prev;
  logic       lock_seen;
  logic       lock_change;
  logic       any_request;
  logic       gated_request;
  logic       request_prev;

  logic [7:0] next_capcmp;
  logic [7:0] next_timer;
  logic [7:0] next_serial;
  logic [7:0] read_value;

  ////////////////////////////////////////////////////////////////////////
  // Event decode

  // Channel flags: bits 7..1 are channels ten..four, bit 0 enhanced three
  always_comb
  begin
    capcmp_set = '0;
    for (int i = 0; i < NUM_CH; i++)
    begin
      capcmp_set[i] = ch_event(CC_MODE[2*i +: 2],
                               CC_CAPTURE[i],
                               CC_COMPARE[i]);
    end
  end

  // Lock edge in either direction; first cycle after reset only primes
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      lock_prev <= 1'b0;
      lock_seen <= 1'b0;
    end
    else
    begin
      lock_prev <= TUNE_LOCKED;
      lock_seen <= 1'b1;
    end
  end

  assign lock_change = lock_seen && (TUNE_LOCKED != lock_prev);

  always_comb
  begin
    timer_set = '0;
    timer_set[pfe_pkg::TUNE_RANGE_BIT] = TUNE_RANGE_ERR;
    timer_set[pfe_pkg::TUNE_LOCK_BIT]  = lock_change;
    timer_set[pfe_pkg::TMR8_MATCH_BIT] = TMR8_MATCH;
    timer_set[pfe_pkg::TMR6_MATCH_BIT] = TMR6_MATCH;
    timer_set[pfe_pkg::TMR4_MATCH_BIT] = TMR4_MATCH;
    timer_set[pfe_pkg::TMR5_OVF_BIT]   = TMR5_OVF;
  end

  always_comb
  begin
    serial_set = '0;
    serial_set[pfe_pkg::SER4_RX_BIT] = SER4_RX_FULL;
    serial_set[pfe_pkg::SER4_TX_BIT] = SER4_TX_EMPTY;
    serial_set[pfe_pkg::SER3_RX_BIT] = SER3_RX_FULL;
    serial_set[pfe_pkg::SER3_TX_BIT] = SER3_TX_EMPTY;
    serial_set[pfe_pkg::CMP1_BIT +: 3] = CMP_EVENT;
  end

  // Buffer accesses clear the serial flags; no software path to them
  always_comb
  begin
    serial_auto_clr = '0;
    serial_auto_clr[pfe_pkg::SER4_RX_BIT] = SER4_RX_BUF_READ;
    serial_auto_clr[pfe_pkg::SER3_RX_BIT] = SER3_RX_BUF_READ;
    serial_auto_clr[pfe_pkg::SER4_TX_BIT] = SER4_TX_BUF_WRITE;
    serial_auto_clr[pfe_pkg::SER3_TX_BIT] = SER3_TX_BUF_WRITE;
  end

  ////////////////////////////////////////////////////////////////////////
  // Flag registers: an event in the cycle of a clearing write wins

  always_comb
  begin
    next_capcmp = capcmp_channel_event_flags;
    if (wr_hit(WR, ADDR, pfe_pkg::OFF_CAPCMP_FLAGS))
    begin
      next_capcmp = WDATA & pfe_pkg::CAPCMP_IMPL_MASK;
    end
    next_capcmp = next_capcmp | capcmp_set;
  end

  always_comb
  begin
    next_timer = timer_and_tuning_event_flags;
    if (wr_hit(WR, ADDR, pfe_pkg::OFF_TIMER_FLAGS))
    begin
      next_timer = WDATA;
    end
    next_timer = (next_timer | timer_set)
                 & pfe_pkg::TIMER_IMPL_MASK;
  end

  always_comb
  begin
    next_serial = serial_and_comparator_event_flags & ~serial_auto_clr;
    if (wr_hit(WR, ADDR, pfe_pkg::OFF_SERIAL_FLAGS))
    begin
      next_serial = (next_serial & ~pfe_pkg::SERIAL_SW_MASK)
                    | (WDATA & pfe_pkg::SERIAL_SW_MASK);
    end
    next_serial = (next_serial | serial_set)
                  & pfe_pkg::SERIAL_IMPL_MASK;
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      capcmp_channel_event_flags        <= pfe_pkg::FLAGS_RESET;
      timer_and_tuning_event_flags      <= pfe_pkg::FLAGS_RESET;
      serial_and_comparator_event_flags <= pfe_pkg::FLAGS_RESET;
    end
    else
    begin
      capcmp_channel_event_flags        <= next_capcmp;
      timer_and_tuning_event_flags      <= next_timer;
      serial_and_comparator_event_flags <= next_serial;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Enable registers, one bit per source, 1 enables

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      peripheral_enable_group_one   <= pfe_pkg::ENABLE_RESET;
      peripheral_enable_group_two   <= pfe_pkg::ENABLE_RESET;
      peripheral_enable_group_three <= pfe_pkg::ENABLE_RESET;
    end
    else
    begin
      if (wr_hit(WR, ADDR, pfe_pkg::OFF_ENABLE_ONE))
      begin
        peripheral_enable_group_one <= WDATA;
      end
      if (wr_hit(WR, ADDR, pfe_pkg::OFF_ENABLE_TWO))
      begin
        peripheral_enable_group_two <= WDATA;
      end
      if (wr_hit(WR, ADDR, pfe_pkg::OFF_ENABLE_THREE))
      begin
        peripheral_enable_group_three <= WDATA;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Control: group enable and priority mode

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      {priority_mode_enable, peripheral_group_enable}
        <= pfe_pkg::CONTROL_RESET;
    end
    else if (wr_hit(WR, ADDR, pfe_pkg::OFF_CONTROL))
    begin
      peripheral_group_enable <= WDATA[pfe_pkg::GROUP_EN_BIT];
      priority_mode_enable    <= WDATA[pfe_pkg::PRIO_MODE_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Peripheral request towards the core

  assign any_request =
      |(GRP1_FLAGS & peripheral_enable_group_one)
    | |(GRP2_FLAGS & peripheral_enable_group_two)
    | |(GRP3_FLAGS & peripheral_enable_group_three)
    | |(capcmp_channel_event_flags & CAPCMP_EN)
    | |(timer_and_tuning_event_flags & TIMER_EN)
    | |(serial_and_comparator_event_flags & SERIAL_EN);

  // In priority mode the core's own enables take over the gating
  assign gated_request = any_request
    && (priority_mode_enable || peripheral_group_enable);

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      PERIPH_IRQ   <= 1'b0;
      request_prev <= 1'b0;
    end
    else
    begin
      PERIPH_IRQ   <= gated_request;
      request_prev <= gated_request;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt status: sticky, cleared by writing ones, set wins

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      irq_status <= pfe_pkg::STATUS_RESET;
    end
    else
    begin
      irq_status <= (irq_status
                     & ~({4{wr_hit(WR, ADDR, pfe_pkg::OFF_IRQ_CLEAR)}}
                         & WDATA[3:0]))
                    | {gated_request && !request_prev,
                       |serial_set,
                       |timer_set,
                       |capcmp_set};
    end
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      irq_enable <= pfe_pkg::STATUS_RESET;
    end
    else if (wr_hit(WR, ADDR, pfe_pkg::OFF_IRQ_ENABLE))
    begin
      irq_enable <= WDATA[3:0] & pfe_pkg::ST_MASK;
    end
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      IRQ <= 1'b0;
    end
    else
    begin
      IRQ <= |(irq_status & irq_enable);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read path: data valid only in the cycle after the strobe

  always_comb
  begin
    read_value = 8'h00;
    case (ADDR)
      pfe_pkg::OFF_CAPCMP_FLAGS: read_value = capcmp_channel_event_flags;
      pfe_pkg::OFF_TIMER_FLAGS:  read_value = timer_and_tuning_event_flags;
      pfe_pkg::OFF_SERIAL_FLAGS:
        read_value = serial_and_comparator_event_flags;
      pfe_pkg::OFF_ENABLE_ONE:   read_value = peripheral_enable_group_one;
      pfe_pkg::OFF_ENABLE_TWO:   read_value = peripheral_enable_group_two;
      pfe_pkg::OFF_ENABLE_THREE:
        read_value = peripheral_enable_group_three;
      pfe_pkg::OFF_CONTROL:
        read_value = {6'h00, priority_mode_enable,
                      peripheral_group_enable};
      pfe_pkg::OFF_IRQ_STATUS:   read_value = {4'h0, irq_status};
      pfe_pkg::OFF_IRQ_ENABLE:   read_value = {4'h0, irq_enable};
      default:                   read_value = 8'h00;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      RDATA <= 8'h00;
    end
    else if (RD)
    begin
      RDATA <= read_value;
    end
    else
    begin
      RDATA <= 8'h00;
    end
  end

endmodule // pfe_bank

// ### tb/pfe_bank_monitor.sv
// Checker of the flag bank register port and request outputs
`timescale 1ns/1ps
module pfe_bank_monitor #(
  parameter int NUM_CH = 8
) (
  // Clock, reset and register port
  input wire logic                CLK,
  input wire logic                RST_N,
  input wire logic [3:0]          ADDR,
  input wire logic [7:0]          WDATA,
  input wire logic                WR,
  input wire logic                RD,
  input wire logic [7:0]          RDATA,
  // Event sources
  input wire logic [2*NUM_CH-1:0] CC_MODE,
  input wire logic [NUM_CH-1:0]   CC_CAPTURE,
  input wire logic [NUM_CH-1:0]   CC_COMPARE,
  input wire logic                TUNE_RANGE_ERR,
  input wire logic                TMR8_MATCH,
  input wire logic                TMR6_MATCH,
  input wire logic                TMR5_OVF,
  input wire logic                TMR4_MATCH,
  input wire logic                SER4_RX_FULL,
  input wire logic                SER4_TX_EMPTY,
  input wire logic                SER3_RX_FULL,
  input wire logic                SER3_TX_EMPTY,
  input wire logic                SER4_RX_BUF_READ,
  input wire logic                SER4_TX_BUF_WRITE,
  input wire logic                SER3_RX_BUF_READ,
  input wire logic                SER3_TX_BUF_WRITE,
  input wire logic [2:0]          CMP_EVENT,
  input wire logic [7:0]          GRP1_FLAGS,
  // Requests
  input wire logic                PERIPH_IRQ,
  input wire logic                IRQ
);
  logic [7:0] cf, tf, sf, en1, en2, en3, cc_hit;
  logic [1:0] ctl;
  logic [3:0] ien;
  logic       gate;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  function automatic logic hit(input logic [3:0] a);
    return WR && ADDR == a;
  endfunction

  assign gate = |ctl;

  always_comb
  begin
    cc_hit = 8'h00;
    for (int i = 0; i < NUM_CH; i++)
      cc_hit[i] = (CC_MODE[2*i+:2] == pfe_pkg::MODE_CAPTURE && CC_CAPTURE[i])
        || (CC_MODE[2*i+:2] == pfe_pkg::MODE_COMPARE && CC_COMPARE[i]);
  end

  //////////////////////////////////////////////////////////////////////////
  // Flag model; an event beats a clearing access in the same cycle
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      cf <= 8'h00;
      tf <= 8'h00;
      sf <= 8'h00;
    end
    else
    begin
      cf <= (hit(pfe_pkg::OFF_CAPCMP_FLAGS) ? WDATA : cf) | cc_hit;
      tf <= ((hit(pfe_pkg::OFF_TIMER_FLAGS) ? WDATA : tf) & 8'h77)
        | {1'b0, TUNE_RANGE_ERR, 1'b0, TMR8_MATCH, 1'b0, TMR6_MATCH,
           TMR5_OVF, TMR4_MATCH};
      sf[7:4] <= (sf[7:4] & ~{SER4_RX_BUF_READ, SER4_TX_BUF_WRITE,
        SER3_RX_BUF_READ, SER3_TX_BUF_WRITE}) | {SER4_RX_FULL,
        SER4_TX_EMPTY, SER3_RX_FULL, SER3_TX_EMPTY};
      sf[2:0] <= (hit(pfe_pkg::OFF_SERIAL_FLAGS) ? WDATA[2:0] : sf[2:0])
        | CMP_EVENT;
    end
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      en1 <= 8'h00;
      en2 <= 8'h00;
      en3 <= 8'h00;
      ctl <= 2'h0;
      ien <= 4'h0;
    end
    else
    begin
      if (hit(pfe_pkg::OFF_ENABLE_ONE)) en1 <= WDATA;
      if (hit(pfe_pkg::OFF_ENABLE_TWO)) en2 <= WDATA;
      if (hit(pfe_pkg::OFF_ENABLE_THREE)) en3 <= WDATA;
      if (hit(pfe_pkg::OFF_CONTROL)) ctl <= WDATA[1:0];
      if (hit(pfe_pkg::OFF_IRQ_ENABLE)) ien <= WDATA[3:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  a_capcmp_read: assert property (
    RD && ADDR == pfe_pkg::OFF_CAPCMP_FLAGS |=> RDATA == $past(cf))
    else $error("channel flag read differs from model");
  a_timer_read: assert property (
    RD && ADDR == pfe_pkg::OFF_TIMER_FLAGS |=>
    (RDATA & 8'h57) == ($past(tf) & 8'h57))
    else $error("timer flag read differs from model");
  a_timer_unimpl: assert property (
    RD && ADDR == pfe_pkg::OFF_TIMER_FLAGS |=> RDATA[7] == 1'b0
    && RDATA[3] == 1'b0)
    else $error("unimplemented timer flag bit read as one");
  a_serial_read: assert property (
    RD && ADDR == pfe_pkg::OFF_SERIAL_FLAGS |=> RDATA == $past(sf))
    else $error("serial flag read differs from model");
  a_enable_readback: assert property (
    RD && ADDR >= pfe_pkg::OFF_ENABLE_ONE && ADDR <= pfe_pkg::OFF_ENABLE_THREE
    |=> RDATA == $past(ADDR == 4'h3 ? en1 : ADDR == 4'h4 ? en2 : en3))
    else $error("enable register read differs from model");
  a_group_gate: assert property (
    !gate [*2] |-> !PERIPH_IRQ)
    else $error("peripheral request while group gate closed");
  a_request_raised: assert property (
    (gate && |(GRP1_FLAGS & en1)) [*3] |-> PERIPH_IRQ)
    else $error("enabled flag gave no peripheral request");
  a_irq_masked: assert property (
    (ien == 4'h0) [*2] |-> !IRQ)
    else $error("interrupt output high with all enables clear");
  a_reset_quiet: assert property (
    $rose(RST_N) |-> !PERIPH_IRQ && !IRQ && RDATA == 8'h00)
    else $error("outputs not quiet after reset");
endmodule // pfe_bank_monitor

bind pfe_bank pfe_bank_monitor #(.NUM_CH(NUM_CH)) u_monitor (.*);

// ### tb/pfe_event_src.sv
// Peripheral event source model: one pulse per command, lock level
`timescale 1ns/1ps
module pfe_event_src (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Command
  input  wire logic        fire,
  input  wire logic [4:0]  sel,
  // Event lines
  output logic      [16:0] pulse,
  output logic             locked
);
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pulse  <= 17'h00000;
      locked <= 1'b0;
    end
    else
    begin
      // Strictly one cycle, as a real timer or port strobe
      pulse <= fire ? 17'h00001 << sel : 17'h00000;
      if (fire && sel == 5'h05)
        locked <= !locked;
    end
  end
endmodule // pfe_event_src

// ### tb/pfe_bank_tb.sv
// Self-checking testbench of the peripheral flag and enable bank
`timescale 1ns/1ps
module pfe_bank_tb;
  logic        CLK, RST_N, WR, RD, fire, locked, PERIPH_IRQ, IRQ;
  logic [3:0]  ADDR;
  logic [7:0]  WDATA, RDATA, d, CC_CAPTURE, CC_COMPARE, GRP1_FLAGS;
  logic [7:0]  GRP2_FLAGS, GRP3_FLAGS, CAPCMP_EN, TIMER_EN, SERIAL_EN;
  logic [15:0] CC_MODE;
  logic [4:0]  sel;
  logic [16:0] pulse;
  int          error_cnt, checked;
  // Row: event select, register, expected flags (flags accumulate)
  logic [19:0] rows [17] = '{20'h00101, 20'h01103, 20'h02107, 20'h03117,
    20'h04157, 20'h05177, 20'h06201, 20'h07203, 20'h08207, 20'h09217,
    20'h0A237, 20'h0B277, 20'h0C2F7, 20'h0D2E7, 20'h0E2C7, 20'h0F287,
    20'h10207};

  pfe_event_src src (.clk(CLK), .rst_n(RST_N), .fire(fire), .sel(sel),
    .pulse(pulse), .locked(locked));
  pfe_bank #(.NUM_CH(8)) dut (.TMR4_MATCH(pulse[0]), .TMR5_OVF(pulse[1]),
    .TMR6_MATCH(pulse[2]), .TMR8_MATCH(pulse[3]),
    .TUNE_RANGE_ERR(pulse[4]), .TUNE_LOCKED(locked),
    .CMP_EVENT(pulse[8:6]), .SER3_TX_EMPTY(pulse[9]),
    .SER3_RX_FULL(pulse[10]), .SER4_TX_EMPTY(pulse[11]),
    .SER4_RX_FULL(pulse[12]), .SER3_TX_BUF_WRITE(pulse[13]),
    .SER3_RX_BUF_READ(pulse[14]), .SER4_TX_BUF_WRITE(pulse[15]),
    .SER4_RX_BUF_READ(pulse[16]), .*);

  initial
  begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    checked++;
    if (s !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge CLK);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge CLK);
    WR <= 1'b0;
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
    @(posedge CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CLK);
    RD <= 1'b0;
    #1 chk("register read", e, RDATA);
  endtask

  task automatic settle();
    repeat (3) @(posedge CLK);
    #1;
  endtask

  task automatic fire_ev(input logic [4:0] s);
    @(posedge CLK);
    fire <= 1'b1;
    sel <= s;
    @(posedge CLK);
    fire <= 1'b0;
    settle();
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  // Whole run is well under a thousand cycles
  initial
  begin
    #20000;
    error_cnt++;
    tally_and_finish();
  end

  initial
  begin
    {RST_N, WR, RD, fire, sel, ADDR, WDATA, CC_MODE} = '0;
    {CC_CAPTURE, CC_COMPARE, GRP1_FLAGS, GRP2_FLAGS, GRP3_FLAGS} = '0;
    {CAPCMP_EN, TIMER_EN, SERIAL_EN} = '0;
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    for (int a = 0; a < 6; a++)
      rdchk(a[3:0], 8'h00);
    rdchk(4'hF, 8'h00);
    $display("reset values done");
    foreach (rows[i])
    begin
      fire_ev(rows[i][16:12]);
      rdchk(rows[i][11:8], rows[i][7:0]);
    end
    $display("event table done");
    wr(4'h1, 8'hFF);
    rdchk(4'h1, 8'h77);
    wr(4'h1, 8'h00);
    rdchk(4'h1, 8'h00);
    wr(4'h2, 8'h00);
    rdchk(4'h2, 8'h00);
    wr(4'h2, 8'hFF);
    rdchk(4'h2, 8'h07);
    wr(4'h2, 8'h00);
    $display("unimplemented bits done");
    // Channel i mode = i mod 4: off, capture, compare, PWM
    @(posedge CLK);
    CC_MODE <= 16'hE4E4;
    CC_CAPTURE <= 8'hFF;
    @(posedge CLK);
    CC_CAPTURE <= 8'h00;
    rdchk(4'h0, 8'h22);
    @(posedge CLK);
    CC_COMPARE <= 8'hFF;
    @(posedge CLK);
    CC_COMPARE <= 8'h00;
    rdchk(4'h0, 8'h66);
    @(posedge CLK);
    {ADDR, WDATA, WR, CC_CAPTURE} <= {4'h0, 8'h00, 1'b1, 8'hFF};
    @(posedge CLK);
    {WR, CC_CAPTURE} <= '0;
    rdchk(4'h0, 8'h22);
    wr(4'h0, 8'h00);
    rdchk(4'h0, 8'h00);
    $display("channel flags done");
    wr(4'h8, 8'h0F);
    wr(4'h9, 8'h02);
    fire_ev(5'h01);
    chk("IRQ", 8'h01, {7'h00, IRQ});
    rdchk(4'h7, 8'h02);
    wr(4'h8, 8'h02);
    settle();
    chk("IRQ", 8'h00, {7'h00, IRQ});
    wr(4'h9, 8'h00);
    fire_ev(5'h01);
    chk("IRQ", 8'h00, {7'h00, IRQ});
    $display("interrupt output done");
    @(posedge CLK);
    TIMER_EN <= 8'h02;
    settle();
    chk("PERIPH_IRQ", 8'h00, {7'h00, PERIPH_IRQ});
    // Priority mode alone also opens the gate
    for (int c = 0; c < 4; c++)
    begin
      wr(4'h6, c[7:0]);
      settle();
      chk("PERIPH_IRQ", {7'h00, c != 0}, {7'h00, PERIPH_IRQ});
    end
    wr(4'h1, 8'h00);
    wr(4'h3, 8'h80);
    GRP1_FLAGS <= 8'h80;
    wr(4'h6, 8'h01);
    settle();
    chk("PERIPH_IRQ", 8'h01, {7'h00, PERIPH_IRQ});
    wr(4'h3, 8'h00);
    settle();
    chk("PERIPH_IRQ", 8'h00, {7'h00, PERIPH_IRQ});
    $display("request gating done");
    for (int a = 3; a < 6; a++)
    begin
      wr(a[3:0], 8'hA5 ^ a[7:0]);
      rdchk(a[3:0], 8'hA5 ^ a[7:0]);
    end
    $display("enable registers done");
    @(posedge CLK);
    {GRP1_FLAGS, GRP2_FLAGS} <= 16'h0080;
    settle();
    chk("PERIPH_IRQ", 8'h01, {7'h00, PERIPH_IRQ});
    @(posedge CLK);
    {GRP2_FLAGS, GRP3_FLAGS} <= 16'h0080;
    settle();
    chk("PERIPH_IRQ", 8'h01, {7'h00, PERIPH_IRQ});
    @(posedge CLK);
    {GRP3_FLAGS, SERIAL_EN} <= 16'h0001;
    settle();
    chk("PERIPH_IRQ", 8'h00, {7'h00, PERIPH_IRQ});
    fire_ev(5'h06);
    chk("PERIPH_IRQ", 8'h01, {7'h00, PERIPH_IRQ});
    wr(4'h6, 8'h00);
    settle();
    chk("PERIPH_IRQ", 8'h00, {7'h00, PERIPH_IRQ});
    rdchk(4'h7, 8'h0E);
    $display("group gating done");
    // Reset in mid-run must clear live flags and enables
    @(posedge CLK);
    RST_N <= 1'b0;
    repeat (2) @(posedge CLK);
    RST_N <= 1'b1;
    rdchk(4'h2, 8'h00);
    rdchk(4'h4, 8'h00);
    chk("PERIPH_IRQ", 8'h00, {7'h00, PERIPH_IRQ});
    $display("mid-run reset done");
    tally_and_finish();
  end
endmodule // pfe_bank_tb
